/* hw/tmr_params.svh */
// Register offsets, field positions and reset values for the timer channel
// Contract
// - Writing 1 to stop bit stops channel counting; writing 0 does nothing.
// - Operation clock select picks prescaled clock A when 0, B when 1.
// - Count clock select: 0 counts operation clock, 1 counts valid input edges.
// - Trigger source 000 means only software start trigger starts the channel.
// - Trigger source 001: each valid input edge is start and capture trigger.
// - Trigger source 010: one input edge starts, the opposite edge captures.
// - Trigger source 100: master channel interrupt serves as this channel's trigger.
// - Edge select: 00 falling, 01 rising, 1x both edges; code: 1x takes falling as valid edge, rising as opposite.
// - Mode 010 is capture mode, counter counts up.
// - Mode 000 interval timer and 011 event counter count down.
// - Mode 100 is one-count mode, counter counts down.
// - Mode 110 is capture/one-count, counts up; other modes prohibited.
// - Interval and capture modes: option bit 1 raises interrupt, toggles output at start.
// - One-count mode: option 0 ignores restarts while counting, 1 accepts with interrupt; code: hardware triggers only, start bit writes always act.
// - Interrupt flag reads 1 while pending, software can clear it.
// - Writing 1 to start bit sets enable status and enables counting.
// - Unit clock supply enable 0 stops the unit clock, 1 supplies it.
// - Prescaler field divides system clock by two to the field value.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define OFS_STOP 12'h000
`define OFS_MODE_HI 12'h004
`define OFS_MODE_LO 12'h008
`define OFS_IRQ_FLAG 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_START 12'h014
`define OFS_CLK_EN 12'h018
`define OFS_PRESCALE 12'h01C
`define OFS_CAPTURE 12'h020
`define OFS_STATUS 12'h024
`define OFS_COUNT 12'h028
`define OFS_RELOAD 12'h02C
`define BIT_CH0 0
`define BIT_OPCLK 7
`define BIT_CNTCLK 4
`define BIT_IRQ 6
`define RST_MODE_HI 8'h00
`define RST_MODE_LO 8'h00
`define RST_MASK 8'h40
`define RST_PRESCALE 8'h00
`define RST_RELOAD 16'hFFFF
`endif

/* hw/tmr_pkg.sv */
// Types shared by the timer channel design
package tmr_pkg;
	typedef enum logic [2:0] {
		MODE_INTERVAL = 3'h0,
		MODE_CAPTURE = 3'h2,
		MODE_EVENT = 3'h3,
		MODE_ONECOUNT = 3'h4,
		MODE_CAP_ONE = 3'h6
	} mode_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h2
	} state_type;
	typedef struct packed {
		logic op_clock_select;
		logic count_clock_select;
		logic [2:0] trigger_source;
		logic [1:0] edge_select;
		logic [2:0] mode_field;
		logic start_interrupt_option;
	} config_type;
endpackage

/* hw/timer_channel.sv */
// One timer channel with capture, count modes and APB register access
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tmr_params.svh"
module timer_channel (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and neighbours
	input wire logic timer_input_pin,
	input wire logic master_interrupt,
	output logic timer_output,
	output logic timer_interrupt
);
	logic [7:0] mode_hi_r;
	logic [7:0] mode_lo_r;
	logic [7:0] prescale_r;
	logic clk_en_r;
	logic flag_r;
	logic mask_r;
	logic enable_r;
	logic [15:0] count_r;
	logic [15:0] capture_r;
	logic [15:0] reload_r;
	logic [14:0] div_r;
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_s3_r;
	logic mirq_s1_r;
	logic mirq_s2_r;
	logic mirq_s3_r;
	tmr_pkg::state_type state_r;
	tmr_pkg::config_type cfg;
	logic wr;
	logic rd;
	logic [7:0] wb;
	logic tick_a;
	logic tick_b;
	logic op_tick;
	logic rise;
	logic fall;
	logic valid_edge;
	logic opp_edge;
	logic start_trig;
	logic cap_trig;
	logic count_tick;
	logic event_irq;
	logic sw_start;
	logic sw_stop;
	logic down_mode;
	logic hit_zero;
	logic [31:0] rd_nxt;
	logic mapped;
	logic mirq_rise;
	logic start_irq;
	logic cap_mode;
	logic cap_now;

	assign cfg = '{mode_hi_r[`BIT_OPCLK], mode_hi_r[`BIT_CNTCLK], mode_hi_r[2:0],
		mode_lo_r[7:6], mode_lo_r[3:1], mode_lo_r[0]};
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign wb = pwdata[7:0];
	assign sw_start = wr && (paddr == `OFS_START) && wb[`BIT_CH0];
	assign sw_stop = wr && (paddr == `OFS_STOP) && wb[`BIT_CH0];

	// Prescaler divider, frozen while unit clock supply is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 15'h0000;
		end else if (clk_en_r) begin
			div_r <= div_r + 15'h0001;
		end
	end

	// Tick when the low N bits of the divider are all ones, one cycle in 2^N
	function automatic logic div_tick(input logic [14:0] d, input logic [3:0] n);
		logic [15:0] m;
		m = (16'h0001 << n) - 16'h0001;
		return (({1'b0, d} & m) == m);
	endfunction
	assign tick_a = clk_en_r && div_tick(div_r, prescale_r[3:0]);
	assign tick_b = clk_en_r && div_tick(div_r, prescale_r[7:4]);
	assign op_tick = cfg.op_clock_select ? tick_b : tick_a;

	// Pin and master interrupt synchronisers, third stage for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
			mirq_s1_r <= 1'b0;
			mirq_s2_r <= 1'b0;
			mirq_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= timer_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			mirq_s1_r <= master_interrupt;
			mirq_s2_r <= mirq_s1_r;
			mirq_s3_r <= mirq_s2_r;
		end
	end
	// Edges taken from the second and third stages, never from the first
	assign rise = pin_s2_r && !pin_s3_r;
	assign fall = !pin_s2_r && pin_s3_r;
	// Master interrupt edge, same depth as the pin so slave starts stay aligned
	assign mirq_rise = mirq_s2_r && !mirq_s3_r;

	// Valid edge choice; in both-edge mode the falling edge opens a low-width window
	always_comb begin
		valid_edge = 1'b0;
		opp_edge = 1'b0;
		if (cfg.edge_select[1]) begin
			valid_edge = fall;
			opp_edge = rise;
		end else if (cfg.edge_select[0]) begin
			valid_edge = rise;
			opp_edge = fall;
		end else begin
			valid_edge = fall;
			opp_edge = rise;
		end
	end

	// Trigger sources; hardware triggers only act once enabled
	always_comb begin
		start_trig = 1'b0;
		cap_trig = 1'b0;
		if (cfg.trigger_source == 3'h1) begin
			start_trig = valid_edge;
			cap_trig = valid_edge;
		end else if (cfg.trigger_source == 3'h2) begin
			start_trig = valid_edge;
			cap_trig = opp_edge;
		end else if (cfg.trigger_source == 3'h4) begin
			start_trig = mirq_rise;
			cap_trig = mirq_rise;
		end
	end

	// Counting clock and direction by mode
	assign count_tick = cfg.count_clock_select ? valid_edge && clk_en_r : op_tick;
	assign down_mode = (cfg.mode_field == tmr_pkg::MODE_INTERVAL) ||
		(cfg.mode_field == tmr_pkg::MODE_EVENT) ||
		(cfg.mode_field == tmr_pkg::MODE_ONECOUNT);
	assign hit_zero = down_mode && count_tick && (count_r == 16'h0000);

	// Start interrupt and output change only in interval and capture modes
	assign start_irq = cfg.start_interrupt_option &&
		((cfg.mode_field == tmr_pkg::MODE_INTERVAL) ||
		(cfg.mode_field == tmr_pkg::MODE_CAPTURE));

	// Capture fires only while running in a capture mode with no trigger write pending
	assign cap_mode = (cfg.mode_field == tmr_pkg::MODE_CAPTURE) ||
		(cfg.mode_field == tmr_pkg::MODE_CAP_ONE);
	assign cap_now = cap_mode && cap_trig && (state_r == tmr_pkg::ST_RUN) &&
		!sw_stop && !sw_start;

	// Channel sequence, counter, capture and interrupt event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= tmr_pkg::ST_IDLE;
			count_r <= 16'h0000;
			event_irq <= 1'b0;
			timer_output <= 1'b0;
		end else begin
			event_irq <= 1'b0;
			if (sw_stop) begin
				state_r <= tmr_pkg::ST_IDLE;
			end else if (sw_start) begin
				// Source 000 runs at once, any other source only arms the channel
				if (cfg.trigger_source == 3'h0) begin
					state_r <= tmr_pkg::ST_RUN;
					count_r <= down_mode ? reload_r : 16'h0000;
					if (start_irq) begin
						event_irq <= 1'b1;
						timer_output <= !timer_output;
					end
				end else begin
					state_r <= tmr_pkg::ST_WAIT;
				end
			end else begin
				case (state_r)
					// Armed: a hardware start trigger begins counting
					tmr_pkg::ST_WAIT: begin
						if (start_trig) begin
							state_r <= tmr_pkg::ST_RUN;
							count_r <= down_mode ? reload_r : 16'h0000;
							if (start_irq) begin
								event_irq <= 1'b1;
								timer_output <= !timer_output;
							end
						end
					end
					tmr_pkg::ST_RUN: begin
						case (cfg.mode_field)
							// Capture: restart from zero so each capture is one interval
							tmr_pkg::MODE_CAPTURE: begin
								if (cap_trig) begin
									count_r <= 16'h0000;
									event_irq <= 1'b1;
								end else if (count_tick) begin
									count_r <= count_r + 16'h0001;
								end
							end
							// Width measurement: capture once, then wait for a new start
							tmr_pkg::MODE_CAP_ONE: begin
								if (cap_trig) begin
									event_irq <= 1'b1;
									state_r <= tmr_pkg::ST_WAIT;
								end else if (count_tick) begin
									count_r <= count_r + 16'h0001;
								end
							end
							// One-count: stop at zero and wait for the next start
							tmr_pkg::MODE_ONECOUNT: begin
								if (start_trig && cfg.start_interrupt_option) begin
									count_r <= reload_r;
									event_irq <= 1'b1;
								end else if (hit_zero) begin
									event_irq <= 1'b1;
									timer_output <= !timer_output;
									state_r <= tmr_pkg::ST_WAIT;
								end else if (count_tick) begin
									count_r <= count_r - 16'h0001;
								end
							end
							// Interval and event counter: reload at zero and keep going
							tmr_pkg::MODE_INTERVAL, tmr_pkg::MODE_EVENT: begin
								if (hit_zero) begin
									count_r <= reload_r;
									event_irq <= 1'b1;
									timer_output <= !timer_output;
								end else if (count_tick) begin
									count_r <= count_r - 16'h0001;
								end
							end
							default: begin
								count_r <= count_r; // Prohibited mode holds
							end
						endcase
					end
					default: begin
						state_r <= tmr_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// Enable status; stop and start never share one write, stop still ranks first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= 1'b0;
		end else if (sw_stop) begin
			enable_r <= 1'b0;
		end else if (sw_start) begin
			enable_r <= 1'b1;
		end
	end

	// Capture register holds its value until the next capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_r <= 16'h0000;
		end else if (cap_now) begin
			capture_r <= count_r;
		end
	end

	// Request flag: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
		end else if (event_irq) begin
			flag_r <= 1'b1;
		end else if (wr && paddr == `OFS_IRQ_FLAG) begin
			flag_r <= wb[`BIT_IRQ];
		end
	end

	// Interrupt output, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_interrupt <= 1'b0;
		end else begin
			timer_interrupt <= flag_r && !mask_r;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_hi_r <= `RST_MODE_HI;
			mode_lo_r <= `RST_MODE_LO;
			mask_r <= 1'(`RST_MASK >> `BIT_IRQ);
			prescale_r <= `RST_PRESCALE;
			clk_en_r <= 1'b0;
			reload_r <= `RST_RELOAD;
		end else if (wr) begin
			if (paddr == `OFS_MODE_HI) begin
				mode_hi_r <= wb & 8'h97;
			end else if (paddr == `OFS_MODE_LO) begin
				mode_lo_r <= wb & 8'hCF;
			end else if (paddr == `OFS_IRQ_MASK) begin
				mask_r <= wb[`BIT_IRQ];
			end else if (paddr == `OFS_PRESCALE) begin
				prescale_r <= wb;
			end else if (paddr == `OFS_CLK_EN) begin
				clk_en_r <= wb[0];
			end else if (paddr == `OFS_RELOAD) begin
				reload_r <= pwdata[15:0];
			end
		end
	end

	// Read mux; unmapped addresses read zero with an error
	always_comb begin
		rd_nxt = 32'h00000000;
		mapped = 1'b1;
		if (paddr == `OFS_MODE_HI) begin
			rd_nxt = {24'h000000, mode_hi_r};
		end else if (paddr == `OFS_MODE_LO) begin
			rd_nxt = {24'h000000, mode_lo_r};
		end else if (paddr == `OFS_IRQ_FLAG) begin
			rd_nxt = {25'h0000000, flag_r, 6'h00};
		end else if (paddr == `OFS_IRQ_MASK) begin
			rd_nxt = {25'h0000000, mask_r, 6'h00};
		end else if (paddr == `OFS_CLK_EN) begin
			rd_nxt = {31'h00000000, clk_en_r};
		end else if (paddr == `OFS_PRESCALE) begin
			rd_nxt = {24'h000000, prescale_r};
		end else if (paddr == `OFS_CAPTURE) begin
			rd_nxt = {16'h0000, capture_r};
		end else if (paddr == `OFS_STATUS) begin
			rd_nxt = {29'h00000000, state_r, enable_r};
		end else if (paddr == `OFS_COUNT) begin
			rd_nxt = {16'h0000, count_r};
		end else if (paddr == `OFS_RELOAD) begin
			rd_nxt = {16'h0000, reload_r};
		end else if (paddr == `OFS_STOP || paddr == `OFS_START) begin
			rd_nxt = 32'h00000000; // Write-only triggers read zero
		end else begin
			mapped = 1'b0;
		end
	end

	// APB answer: zero wait states, registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_nxt;
			end
		end
	end
endmodule

/* dv/pulse_source.sv */
// Pulse source model on the timer input pin
`timescale 1ns/1ps
module pulse_source (
	// Clock
	input wire logic pclk,
	// Pin, push-pull, so it never floats
	output logic timer_input_pin
);
	initial timer_input_pin = 1'b0;
	// Rise after gap cycles, high two cycles so both edges pass the synchroniser
	task automatic pulse(input int gap);
		repeat (gap) @(posedge pclk);
		timer_input_pin <= 1'b1;
		repeat (2) @(posedge pclk);
		timer_input_pin <= 1'b0;
	endtask
endmodule

/* dv/timer_channel_assertions.sv */
// Bus and register read checks on the timer channel ports
`timescale 1ns/1ps
`include "tmr_params.svh"
module timer_channel_assertions (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic timer_input_pin,
	input wire logic master_interrupt,
	input wire logic timer_output,
	input wire logic timer_interrupt
);
	logic acc;
	// Completed access, as the master sees it
	assign acc = psel && penable && pready;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("No ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("Ready held too long");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("Ready outside access");
	chk_err_unmapped: assert property (acc && paddr > 12'h02C |-> pslverr)
		else $error("Unmapped access not refused");
	chk_err_mapped: assert property (acc && paddr <= 12'h02C |-> !pslverr)
		else $error("Mapped access refused");
	chk_trig_read_zero: assert property (acc && !pwrite &&
		(paddr == `OFS_STOP || paddr == `OFS_START) |-> prdata == 32'h0)
		else $error("Trigger register read nonzero");
	chk_flag_field: assert property (acc && !pwrite && paddr == `OFS_IRQ_FLAG
		|-> (prdata & 32'hFFFFFFBF) == 32'h0)
		else $error("Flag read has stray bits");
	// Read data only moves after a read setup, so stale data is never lost early
	chk_rdata_cause: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("Read data changed without read");
	cover property (acc && pslverr);
	cover property ($rose(timer_interrupt));
	cover property (acc && !pwrite && paddr == `OFS_CAPTURE);
endmodule
bind timer_channel timer_channel_assertions i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
	.master_interrupt(master_interrupt), .timer_output(timer_output),
	.timer_interrupt(timer_interrupt));

/* dv/tb.sv */
// Self-checking testbench for the timer channel
`timescale 1ns/1ps
`include "tmr_params.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic timer_input_pin, timer_output, timer_interrupt, master_interrupt;
	int err_total, comparisons;
	// 50 MHz clock
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;
	// Master channel interrupt driven by the bench for slave starts
	timer_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_input_pin(timer_input_pin),
		.master_interrupt(master_interrupt),
		.timer_output(timer_output), .timer_interrupt(timer_interrupt));
	pulse_source i_src (.pclk(pclk), .timer_input_pin(timer_input_pin));
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request held until pready is sampled high at a rising edge; data taken and released there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(n, e, rd);
	endtask
	task automatic resets;
		rdc("mode high", `OFS_MODE_HI, 32'h0);
		rdc("mask", `OFS_IRQ_MASK, 32'h40);
		rdc("reload", `OFS_RELOAD, 32'hFFFF);
		rdc("unmapped", 12'h030, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, `OFS_CLK_EN, 32'h1);
	endtask
	// Two intervals of 32 and 64 cycles; the capture step cancels pipeline offsets
	task automatic measure(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ps,
		input int sh);
		logic [31:0] c1;
		apb(1'b1, `OFS_STOP, 32'h1);
		rdc("stopped", `OFS_STATUS, 32'h0);
		apb(1'b1, `OFS_PRESCALE, {24'h0, ps});
		apb(1'b1, `OFS_MODE_HI, {24'h0, hi});
		apb(1'b1, `OFS_MODE_LO, {24'h0, lo});
		apb(1'b1, `OFS_IRQ_MASK, 32'h0);
		apb(1'b1, `OFS_START, 32'h1);
		apb(1'b0, `OFS_STATUS, 32'h0);
		cmp("enable", 32'h1, rd & 32'h1);
		cmp("no start irq", 32'h0, {31'h0, timer_interrupt});
		fork
			begin
				i_src.pulse(4);
				i_src.pulse(30);
				i_src.pulse(62);
			end
			begin
				repeat (48) @(posedge pclk);
				apb(1'b0, `OFS_CAPTURE, 32'h0);
				c1 = rd;
			end
		join
		repeat (10) @(posedge pclk);
		apb(1'b0, `OFS_CAPTURE, 32'h0);
		cmp("capture step", 32'd32 >> sh, rd - c1);
		cmp("irq", 32'h1, {31'h0, timer_interrupt});
		rdc("flag set", `OFS_IRQ_FLAG, 32'h40);
		apb(1'b1, `OFS_IRQ_MASK, 32'h40);
		repeat (2) @(posedge pclk);
		cmp("irq masked", 32'h0, {31'h0, timer_interrupt});
		apb(1'b1, `OFS_IRQ_FLAG, 32'h0);
		rdc("flag clear", `OFS_IRQ_FLAG, 32'h0);
	endtask
	task automatic interval;
		logic [31:0] c1;
		apb(1'b1, `OFS_STOP, 32'h1);
		apb(1'b1, `OFS_MODE_HI, 32'h0);
		apb(1'b1, `OFS_MODE_LO, 32'h1);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0);
		apb(1'b1, `OFS_START, 32'h1);
		repeat (8) @(posedge pclk);
		cmp("start irq", 32'h1, {31'h0, timer_interrupt});
		cmp("start output", 32'h1, {31'h0, timer_output});
		apb(1'b0, `OFS_COUNT, 32'h0);
		c1 = rd;
		apb(1'b0, `OFS_COUNT, 32'h0);
		cmp("count down", 32'h1, {31'h0, rd < c1});
	endtask
	// Master interrupt edges start and then capture; pin edges are ignored meanwhile
	task automatic slave_start;
		apb(1'b1, `OFS_STOP, 32'h1);
		apb(1'b1, `OFS_MODE_HI, 32'h4);
		apb(1'b1, `OFS_MODE_LO, 32'h4);
		apb(1'b1, `OFS_IRQ_FLAG, 32'h0);
		apb(1'b1, `OFS_START, 32'h1);
		i_src.pulse(2);
		repeat (4) @(posedge pclk);
		rdc("armed", `OFS_STATUS, 32'h3);
		master_interrupt <= 1'b1;
		repeat (6) @(posedge pclk);
		master_interrupt <= 1'b0;
		rdc("slave run", `OFS_STATUS, 32'h5);
		rdc("no capture yet", `OFS_IRQ_FLAG, 32'h0);
		master_interrupt <= 1'b1;
		repeat (6) @(posedge pclk);
		master_interrupt <= 1'b0;
		rdc("slave capture", `OFS_IRQ_FLAG, 32'h40);
	endtask
	// Event counter on rising pin edges, then one-count from a short reload
	task automatic down_counts;
		apb(1'b1, `OFS_STOP, 32'h1);
		apb(1'b1, `OFS_RELOAD, 32'h3);
		apb(1'b1, `OFS_MODE_HI, 32'h10);
		apb(1'b1, `OFS_MODE_LO, 32'h46);
		apb(1'b1, `OFS_IRQ_FLAG, 32'h0);
		apb(1'b1, `OFS_START, 32'h1);
		i_src.pulse(2);
		i_src.pulse(2);
		repeat (4) @(posedge pclk);
		rdc("edge count", `OFS_COUNT, 32'h1);
		rdc("no event irq", `OFS_IRQ_FLAG, 32'h0);
		i_src.pulse(2);
		i_src.pulse(2);
		repeat (4) @(posedge pclk);
		rdc("event reload", `OFS_COUNT, 32'h3);
		rdc("event irq", `OFS_IRQ_FLAG, 32'h40);
		cmp("event output", 32'h0, {31'h0, timer_output});
		apb(1'b1, `OFS_STOP, 32'h1);
		apb(1'b1, `OFS_MODE_HI, 32'h0);
		apb(1'b1, `OFS_MODE_LO, 32'h8);
		apb(1'b1, `OFS_IRQ_FLAG, 32'h0);
		apb(1'b1, `OFS_START, 32'h1);
		repeat (8) @(posedge pclk);
		rdc("one-count done", `OFS_STATUS, 32'h3);
		rdc("one-count irq", `OFS_IRQ_FLAG, 32'h40);
		cmp("one-count output", 32'h1, {31'h0, timer_output});
	endtask
	task automatic conclude;
		$display("Comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		master_interrupt = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		resets();
		measure(8'h01, 8'h44, 8'h00, 0);
		measure(8'h81, 8'h04, 8'h30, 3);
		interval();
		slave_start();
		down_counts();
		conclude();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		conclude();
	end
endmodule
